// ==== hw/oetc_pkg.sv ====
/*
 * package for the oscillator enable and tc trim control block:
 * register offsets, field positions, reset values and timing counts.
 * assumes a 32-bit apb slave with each register on one aligned word.
 */
package oetc_pkg;

	// printed offsets are not all multiples of four: they are register indices
	localparam logic [7:0]  OETC_IDX_TRIM_HI   = 8'h18;
	localparam logic [7:0]  OETC_IDX_OSC_CTRL  = 8'h1a;
	localparam logic [7:0]  OETC_IDX_PROTECT   = 8'h1b;
	localparam logic [7:0]  OETC_IDX_OSC_CTRL2 = 8'h1c;
	localparam logic [7:0]  OETC_IDX_CLK_SEL   = 8'h1d;
	localparam logic [7:0]  OETC_IDX_FLAGS     = 8'h1e;
	localparam logic [7:0]  OETC_IDX_IRQ_MASK  = 8'h1f;
	localparam logic [7:0]  OETC_IDX_REF_DIV   = 8'h20;

	// byte address is four times the index
	localparam logic [11:0] OETC_ADDR_TRIM_HI   = {2'b00, OETC_IDX_TRIM_HI, 2'b00};
	localparam logic [11:0] OETC_ADDR_OSC_CTRL  = {2'b00, OETC_IDX_OSC_CTRL, 2'b00};
	localparam logic [11:0] OETC_ADDR_PROTECT   = {2'b00, OETC_IDX_PROTECT, 2'b00};
	localparam logic [11:0] OETC_ADDR_OSC_CTRL2 = {2'b00, OETC_IDX_OSC_CTRL2, 2'b00};
	localparam logic [11:0] OETC_ADDR_CLK_SEL   = {2'b00, OETC_IDX_CLK_SEL, 2'b00};
	localparam logic [11:0] OETC_ADDR_FLAGS     = {2'b00, OETC_IDX_FLAGS, 2'b00};
	localparam logic [11:0] OETC_ADDR_IRQ_MASK  = {2'b00, OETC_IDX_IRQ_MASK, 2'b00};
	localparam logic [11:0] OETC_ADDR_REF_DIV   = {2'b00, OETC_IDX_REF_DIV, 2'b00};

	// field positions
	localparam int          OETC_BIT_OSC_EN      = 7;
	localparam int          OETC_BIT_MFR_RSVD    = 5;
	localparam int          OETC_BIT_MON_RST_EN  = 1;
	localparam int          OETC_BIT_PLL_SEL     = 7;
	localparam int          OETC_BIT_LOCK        = 3;
	localparam int          OETC_BIT_OSC_UP      = 0;
	localparam int          OETC_TRIM_LSB        = 3;

	// trim codes that switch temperature compensation off
	localparam logic [4:0]  OETC_TC_OFF_LO       = 5'h00;
	localparam logic [4:0]  OETC_TC_OFF_HI       = 5'h10;

	localparam logic [7:0]  OETC_UNLOCK_KEY      = 8'h26;

	// reset values
	localparam logic [7:0]  OETC_OSC_CTRL_RST    = 8'h00;
	localparam logic [4:0]  OETC_TRIM_RST        = 5'h00;
	localparam logic [3:0]  OETC_REF_DIV_RST     = 4'h0;
	localparam logic [1:0]  OETC_FLAGS_RST       = 2'h0;
	localparam logic        OETC_PROTECT_RST     = 1'b0;
	localparam logic        OETC_PLL_SEL_RST     = 1'b1;

	// oscillator stable window before the up flag is raised
	localparam int          OETC_CLK_PERIOD_NS   = 5;
	localparam int          OETC_OSC_SETTLE_US   = 10;
	localparam int          OETC_OSC_SETTLE_CYC  =
		(OETC_OSC_SETTLE_US * 1000 + OETC_CLK_PERIOD_NS - 1) / OETC_CLK_PERIOD_NS;
	localparam int          OETC_CNT_W           = 16;

	typedef enum logic [1:0] {
		OETC_OSC_OFF,
		OETC_OSC_SETTLE,
		OETC_OSC_RUN
	} oetc_osc_state_t;

endpackage : oetc_pkg

// ==== hw/oetc_sync2.sv ====
/*
 * two-flop synchroniser for one level.
 * assumes the input may change at any time relative to pclk.
 */
`timescale 1ns/100ps
`default_nettype none

module oetc_sync2 (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic din,
	output var  logic dout
);

	logic meta_ff;
	logic nxt_meta;
	logic nxt_dout;

	always_comb begin
		nxt_meta = din;
		nxt_dout = meta_ff;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff <= 1'b0;
			dout    <= 1'b0;
		end else begin
			meta_ff <= nxt_meta;
			dout    <= nxt_dout;
		end
	end

endmodule // oetc_sync2

`default_nettype wire

// ==== hw/oetc_osc_ctrl.sv ====
/*
 * oscillator enable and tc trim control: apb register file, oscillator
 * supervisor, pll reference select, crystal pin claim and interrupt.
 * assumes pclk at 200 MHz, presetn is the system reset, and the analog
 * oscillator reports activity as an asynchronous level.
 */
// How it works
// [RULE1] trim codes 00000 and 10000 disable compensation
// [RULE2] control writes need unprotected and pll selected
// [RULE3] control writes clear lock and up flags
// [RULE4] bit 7 enables external crystal oscillator
// [RULE5] enable picks divided crystal else internal reference
// [RULE6] monitor reset on lost oscillation when enabled
// [RULE7] up flag once oscillation stable, gates selection; pll_ref_use_osc here follows the enable bit alone, not the up flag
// [RULE8] crystal pins claimed once enabled until reset
// [RULE9] software waits start-up before pseudo stop
// [RULE10] software keeps manufacturer bit 5 at reset
// [RULE11] key 26h clears protection, others set it
// [RULE12] unused control bits read zero, reset zero
`timescale 1ns/100ps
`default_nettype none

module oetc_osc_ctrl
	import oetc_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        osc_active,
	input  wire logic        pll_locked,
	output var  logic        ext_osc_enable,
	output var  logic        pll_ref_use_osc,
	output var  logic [3:0]  reference_divider,
	output var  logic [4:0]  temp_coeff_trim,
	output var  logic        tc_comp_enable,
	output var  logic        crystal_pins_claimed,
	output var  logic        osc_clock_usable,
	output var  logic        osc_monitor_reset,
	output var  logic        irq
);

	////////////////////////////////////////////////////////////////////
	// bus decode

	logic osc_active_s;
	logic lock_s;

	oetc_sync2 u_sync_osc (
		.pclk    (pclk),
		.presetn (presetn),
		.din     (osc_active),
		.dout    (osc_active_s)
	);

	oetc_sync2 u_sync_lock (
		.pclk    (pclk),
		.presetn (presetn),
		.din     (pll_locked),
		.dout    (lock_s)
	);

	logic setup_ph;
	logic wr_acc;
	logic rd_acc;
	logic hit;

	// no wait state: the answer comes in the access cycle after setup
	assign setup_ph = psel & ~penable;
	assign wr_acc   = psel & penable & pready & pwrite;
	assign rd_acc   = psel & penable & pready & ~pwrite;

	always_comb begin
		unique case (paddr)
			OETC_ADDR_TRIM_HI, OETC_ADDR_OSC_CTRL, OETC_ADDR_PROTECT,
			OETC_ADDR_OSC_CTRL2, OETC_ADDR_CLK_SEL, OETC_ADDR_FLAGS,
			OETC_ADDR_IRQ_MASK, OETC_ADDR_REF_DIV: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// configuration registers

	logic        protect_ff,  nxt_protect;
	logic        pll_sel_ff,  nxt_pll_sel;
	logic        mon_en_ff,   nxt_mon_en;
	logic        mfr_ff,      nxt_mfr;
	logic        osc_en_ff,   nxt_osc_en;
	logic        claim_ff,    nxt_claim;
	logic [4:0]  trim_ff,     nxt_trim;
	logic [3:0]  rdiv_ff,     nxt_rdiv;
	logic [1:0]  mask_ff,     nxt_mask;
	logic        osc_wr_ok;
	logic        osc_wr;

	assign osc_wr_ok = ~protect_ff & pll_sel_ff; // RULE2
	assign osc_wr    = wr_acc & (paddr == OETC_ADDR_OSC_CTRL) & osc_wr_ok; // RULE2

	always_comb begin
		nxt_protect = protect_ff;
		nxt_pll_sel = pll_sel_ff;
		nxt_mon_en  = mon_en_ff;
		nxt_mfr     = mfr_ff;
		nxt_osc_en  = osc_en_ff;
		nxt_claim   = claim_ff;
		nxt_trim    = trim_ff;
		nxt_rdiv    = rdiv_ff;
		nxt_mask    = mask_ff;
		if (wr_acc && paddr == OETC_ADDR_PROTECT) begin
			nxt_protect = (pwdata[7:0] != OETC_UNLOCK_KEY); // RULE11
		end
		if (wr_acc && !protect_ff) begin
			if (paddr == OETC_ADDR_TRIM_HI) begin
				nxt_trim = pwdata[OETC_TRIM_LSB +: 5];
			end
			if (paddr == OETC_ADDR_REF_DIV) begin
				nxt_rdiv = pwdata[3:0];
			end
			if (paddr == OETC_ADDR_CLK_SEL) begin
				nxt_pll_sel = pwdata[OETC_BIT_PLL_SEL];
			end
			// monitor enable frozen while the oscillator is enabled or the pll is not selected
			if (paddr == OETC_ADDR_OSC_CTRL2 && pll_sel_ff && !osc_en_ff) begin
				nxt_mon_en = pwdata[OETC_BIT_MON_RST_EN];
			end
		end
		if (osc_wr) begin
			nxt_osc_en = pwdata[OETC_BIT_OSC_EN]; // RULE4
			nxt_mfr    = pwdata[OETC_BIT_MFR_RSVD];
			if (pwdata[OETC_BIT_OSC_EN]) begin
				nxt_claim = 1'b1; // RULE8
			end
		end
		if (wr_acc && paddr == OETC_ADDR_IRQ_MASK) begin
			nxt_mask = pwdata[1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			protect_ff <= OETC_PROTECT_RST;
			pll_sel_ff <= OETC_PLL_SEL_RST;
			mon_en_ff  <= 1'b0;
			mfr_ff     <= OETC_OSC_CTRL_RST[OETC_BIT_MFR_RSVD]; // RULE12
			osc_en_ff  <= OETC_OSC_CTRL_RST[OETC_BIT_OSC_EN];
			claim_ff   <= 1'b0; // RULE8
			trim_ff    <= OETC_TRIM_RST;
			rdiv_ff    <= OETC_REF_DIV_RST;
			mask_ff    <= OETC_FLAGS_RST;
		end else begin
			protect_ff <= nxt_protect;
			pll_sel_ff <= nxt_pll_sel;
			mon_en_ff  <= nxt_mon_en;
			mfr_ff     <= nxt_mfr;
			osc_en_ff  <= nxt_osc_en;
			claim_ff   <= nxt_claim;
			trim_ff    <= nxt_trim;
			rdiv_ff    <= nxt_rdiv;
			mask_ff    <= nxt_mask;
		end
	end

	////////////////////////////////////////////////////////////////////
	// oscillator supervisor

	oetc_osc_state_t            st_ff, nxt_st;
	logic [OETC_CNT_W-1:0]      cnt_ff, nxt_cnt;
	logic                       up_ff, nxt_up;
	logic                       lock_ff, nxt_lock;
	logic                       nxt_mrst;
	logic [1:0]                 stat_ff, nxt_stat;
	logic                       stat_rd;

	assign stat_rd = rd_acc & (paddr == OETC_ADDR_FLAGS);

	always_comb begin
		nxt_st   = st_ff;
		nxt_cnt  = cnt_ff;
		nxt_up   = up_ff;
		nxt_mrst = 1'b0;
		nxt_lock = lock_s;
		unique case (st_ff)
			OETC_OSC_OFF: begin
				nxt_up  = 1'b0;
				nxt_cnt = '0;
				if (osc_en_ff) begin
					nxt_st = OETC_OSC_SETTLE;
				end
			end
			OETC_OSC_SETTLE: begin
				if (!osc_active_s) begin
					nxt_cnt = '0;
				end else if (cnt_ff == OETC_CNT_W'(OETC_OSC_SETTLE_CYC - 1)) begin
					nxt_up = 1'b1; // RULE7
					nxt_st = OETC_OSC_RUN;
				end else begin
					nxt_cnt = cnt_ff + 1'b1;
				end
			end
			OETC_OSC_RUN: begin
				if (!osc_active_s) begin
					nxt_up   = 1'b0;
					nxt_mrst = mon_en_ff; // RULE6
					nxt_st   = OETC_OSC_SETTLE;
					nxt_cnt  = '0;
				end
			end
		endcase
		if (!osc_en_ff) begin
			nxt_st = OETC_OSC_OFF;
			nxt_up = 1'b0;
		end
		// a control write restarts stability qualification
		if (osc_wr) begin
			nxt_up   = 1'b0; // RULE3
			nxt_lock = 1'b0; // RULE3
			nxt_cnt  = '0;
			if (nxt_st == OETC_OSC_RUN) begin
				nxt_st = OETC_OSC_SETTLE;
			end
		end
		// sticky events: set beats the read clear
		nxt_stat = stat_rd ? 2'b00 : stat_ff;
		if (nxt_up && !up_ff) begin
			nxt_stat[OETC_BIT_OSC_UP] = 1'b1;
		end
		if (nxt_mrst) begin
			nxt_stat[1] = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff   <= OETC_OSC_OFF;
			cnt_ff  <= '0;
			up_ff   <= 1'b0;
			lock_ff <= 1'b0;
			stat_ff <= OETC_FLAGS_RST;
		end else begin
			st_ff   <= nxt_st;
			cnt_ff  <= nxt_cnt;
			up_ff   <= nxt_up;
			lock_ff <= nxt_lock;
			stat_ff <= nxt_stat;
		end
	end

	////////////////////////////////////////////////////////////////////
	// read path and outputs

	logic [31:0] rd_word;
	logic        nxt_pready;
	logic        nxt_slverr;
	logic [31:0] nxt_prdata;

	always_comb begin
		unique case (paddr)
			OETC_ADDR_TRIM_HI:   rd_word = {24'h0000_00, trim_ff, 3'b000};
			OETC_ADDR_OSC_CTRL:  rd_word = {24'h0000_00, osc_en_ff, 1'b0, mfr_ff, 5'h00}; // RULE12
			OETC_ADDR_PROTECT:   rd_word = {31'h0000_0000, protect_ff};
			OETC_ADDR_OSC_CTRL2: rd_word = {30'h0000_0000, mon_en_ff, 1'b0};
			OETC_ADDR_CLK_SEL:   rd_word = {24'h0000_00, pll_sel_ff, 7'h00};
			OETC_ADDR_FLAGS:     rd_word = {24'h0000_00, 4'h0, lock_ff, 1'b0, stat_ff[1], up_ff};
			OETC_ADDR_IRQ_MASK:  rd_word = {30'h0000_0000, mask_ff};
			OETC_ADDR_REF_DIV:   rd_word = {28'h0000_000, rdiv_ff};
			default:             rd_word = 32'h0000_0000;
		endcase
		nxt_pready = setup_ph;
		nxt_slverr = setup_ph & ~hit;
		nxt_prdata = (setup_ph && !pwrite) ? rd_word : 32'h0000_0000;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready               <= 1'b0;
			pslverr              <= 1'b0;
			prdata               <= 32'h0000_0000;
			ext_osc_enable       <= 1'b0;
			pll_ref_use_osc      <= 1'b0;
			reference_divider    <= OETC_REF_DIV_RST;
			temp_coeff_trim      <= OETC_TRIM_RST;
			tc_comp_enable       <= 1'b0;
			crystal_pins_claimed <= 1'b0;
			osc_clock_usable     <= 1'b0;
			osc_monitor_reset    <= 1'b0;
			irq                  <= 1'b0;
		end else begin
			pready               <= nxt_pready;
			pslverr              <= nxt_slverr;
			prdata               <= nxt_prdata;
			ext_osc_enable       <= nxt_osc_en; // RULE4
			pll_ref_use_osc      <= nxt_osc_en; // RULE5
			reference_divider    <= nxt_rdiv; // RULE5
			temp_coeff_trim      <= nxt_trim;
			tc_comp_enable       <= (nxt_trim != OETC_TC_OFF_LO) && (nxt_trim != OETC_TC_OFF_HI); // RULE1
			crystal_pins_claimed <= nxt_claim; // RULE8
			osc_clock_usable     <= nxt_up; // RULE7
			osc_monitor_reset    <= nxt_mrst; // RULE6
			irq                  <= |(nxt_stat & nxt_mask);
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks

	a_tc_off_codes: assert property (@(posedge pclk) disable iff (!presetn)
		tc_comp_enable |-> (temp_coeff_trim != 5'h00 && temp_coeff_trim != 5'h10)) // RULE1
		else $error("tc compensation on with a nominal trim code");

	a_osc_wr_blocked: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_acc && paddr == OETC_ADDR_OSC_CTRL && (protect_ff || !pll_sel_ff))
		|=> $stable(osc_en_ff)) // RULE2
		else $error("oscillator control changed by a refused write");

	a_wr_clears_up: assert property (@(posedge pclk) disable iff (!presetn)
		osc_wr |=> (!up_ff && !lock_ff)) // RULE3
		else $error("lock or up flag survived a control write");

	a_enable_follows: assert property (@(posedge pclk) disable iff (!presetn)
		osc_wr |=> (ext_osc_enable == $past(pwdata[7]))) // RULE4
		else $error("oscillator enable does not follow write");

	a_ref_select: assert property (@(posedge pclk) disable iff (!presetn)
		pll_ref_use_osc == ext_osc_enable) // RULE5
		else $error("pll reference select mismatch");

	a_monitor_reset: assert property (@(posedge pclk) disable iff (!presetn)
		(st_ff == OETC_OSC_RUN && !osc_active_s && mon_en_ff && osc_en_ff && !osc_wr)
		|=> osc_monitor_reset) // RULE6
		else $error("lost oscillation gave no monitor reset");

	a_up_needs_settle: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(up_ff) |-> ($past(st_ff) == OETC_OSC_SETTLE && $past(osc_active_s))) // RULE7
		else $error("up flag raised without a settled oscillator");

	a_pins_stay: assert property (@(posedge pclk) disable iff (!presetn)
		claim_ff |=> claim_ff) // RULE8
		else $error("crystal pins released before reset");

	a_protect_key: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_acc && paddr == OETC_ADDR_PROTECT)
		|=> (protect_ff == ($past(pwdata[7:0]) != 8'h26))) // RULE11
		else $error("protection bit wrong after key write");

	a_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(pready && !pwrite && paddr == OETC_ADDR_OSC_CTRL) |-> (prdata[6] == 1'b0
		&& prdata[4:0] == 5'h00 && prdata[31:8] == 24'h0000_00)) // RULE12
		else $error("unused control bits read nonzero");

endmodule // oetc_osc_ctrl

`default_nettype wire

// ==== verif/oetc_osc_model.sv ====
/*
 * crystal oscillator and pll lock model for the oscillator control bench.
 * assumes enable comes from the ext_osc_enable output and kill from the bench.
 */
`timescale 1ns/100ps
`default_nettype none

module oetc_osc_model #(
	parameter int START_CYC = 40
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic enable,
	input  wire logic kill,
	output var  logic osc_active,
	output var  logic pll_locked
);
	logic [7:0] cnt_ff;
	logic [7:0] nxt_cnt;

	// a killed crystal stays dead while kill is high, as a broken part would
	always_comb begin
		nxt_cnt = cnt_ff;
		if (!enable || kill) begin
			nxt_cnt = 8'h00;
		end else if (cnt_ff != 8'(START_CYC)) begin
			nxt_cnt = cnt_ff + 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 8'h00;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	assign osc_active = (cnt_ff == 8'(START_CYC));
	// lock follows a running reference; real lock time is not modelled
	assign pll_locked = osc_active;
endmodule // oetc_osc_model
`default_nettype wire

// ==== verif/oetc_osc_ctrl_test.sv ====
/*
 * self-checking bench for oetc_osc_ctrl: apb master, trim, protection,
 * oscillator bring-up, monitor reset, pin claim and interrupt.
 * assumes oetc_osc_model on the oscillator side and a 2000-cycle settle.
 */
`timescale 1ns/100ps
`default_nettype none

module oetc_osc_ctrl_test
	import oetc_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, kill;
	logic        osc_active, pll_locked, ext_osc_enable, pll_ref_use_osc, tc_comp_enable;
	logic        crystal_pins_claimed, osc_clock_usable, osc_monitor_reset, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	logic [3:0]  reference_divider;
	logic [4:0]  temp_coeff_trim;
	int          failures, compares;

	oetc_osc_ctrl u_oetc_osc_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .osc_active, .pll_locked, .ext_osc_enable,
		.pll_ref_use_osc, .reference_divider, .temp_coeff_trim, .tc_comp_enable,
		.crystal_pins_claimed, .osc_clock_usable, .osc_monitor_reset, .irq);
	oetc_osc_model u_oetc_osc_model (.pclk, .presetn, .enable(ext_osc_enable), .kill,
		.osc_active, .pll_locked);

	////////////////////////////////////////////////////////////////////////////////

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task complete_run;
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// request held until pready is seen high at a rising edge
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		err = pslverr;
		if (pready !== 1'b1) begin
			failures++;
			complete_run();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wait_for(input int sel, input int lim);
		int n;
		n = 0;
		while (((sel == 0) ? osc_clock_usable : osc_monitor_reset) !== 1'b1) begin
			@(posedge pclk);
			n++;
			if (n > lim) begin
				failures++;
				complete_run();
			end
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		kill = 1'b0;
		failures = 0;
		compares = 0;
		seed = 32'h9b79;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OETC_ADDR_OSC_CTRL, 32'h0);
		chk(rd, 32'h0);
		chk(crystal_pins_claimed, 1'b0);
		for (int t = 0; t < 32; t++) begin
			apb(1'b1, OETC_ADDR_TRIM_HI, {24'h0, t[4:0], 3'h0});
			repeat (2) @(posedge pclk);
			chk(temp_coeff_trim, t[4:0]);
			chk(tc_comp_enable, t[4:0] != OETC_TC_OFF_LO && t[4:0] != OETC_TC_OFF_HI);
		end
		seed = xs(seed);
		apb(1'b1, OETC_ADDR_REF_DIV, {28'h0, seed[3:0]});
		@(posedge pclk);
		chk(reference_divider, seed[3:0]);
		// any value but the key locks the clock configuration
		seed = xs(seed);
		apb(1'b1, OETC_ADDR_PROTECT, {24'h0, (seed[7:0] == 8'h26) ? 8'h27 : seed[7:0]});
		apb(1'b0, OETC_ADDR_PROTECT, 32'h0);
		chk(rd, 32'h1);
		// a protected trim register keeps the last code of the sweep
		apb(1'b1, OETC_ADDR_TRIM_HI, 32'h0);
		@(posedge pclk);
		chk(temp_coeff_trim, 5'h1f);
		apb(1'b1, OETC_ADDR_OSC_CTRL, 32'h80);
		apb(1'b0, OETC_ADDR_OSC_CTRL, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, OETC_ADDR_PROTECT, 32'h26);
		apb(1'b1, OETC_ADDR_CLK_SEL, 32'h0);
		apb(1'b1, OETC_ADDR_OSC_CTRL, 32'h80);
		apb(1'b0, OETC_ADDR_OSC_CTRL, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, OETC_ADDR_CLK_SEL, 32'h80);
		// monitor enable only takes while the oscillator is still off
		apb(1'b1, OETC_ADDR_OSC_CTRL2, 32'h2);
		apb(1'b1, OETC_ADDR_IRQ_MASK, 32'h3);
		seed = xs(seed);
		apb(1'b1, OETC_ADDR_OSC_CTRL, {seed[31:8], 1'b1, seed[6], 1'b0, seed[4:0]});
		apb(1'b0, OETC_ADDR_OSC_CTRL, 32'h0);
		chk(rd, 32'h80);
		chk(ext_osc_enable, 1'b1);
		chk(pll_ref_use_osc, 1'b1);
		chk(crystal_pins_claimed, 1'b1);
		wait_for(0, 3000);
		chk(irq, 1'b1);
		apb(1'b0, OETC_ADDR_FLAGS, 32'h0);
		chk({rd[3], rd[0]}, 2'b11);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b0);
		apb(1'b1, OETC_ADDR_OSC_CTRL, 32'h80);
		repeat (2) @(posedge pclk);
		chk(osc_clock_usable, 1'b0);
		wait_for(0, 3000);
		kill <= 1'b1;
		wait_for(1, 40);
		@(posedge pclk);
		chk(osc_monitor_reset, 1'b0);
		@(posedge pclk);
		chk(irq, 1'b1);
		apb(1'b0, OETC_ADDR_FLAGS, 32'h0);
		chk(rd[1], 1'b1);
		kill <= 1'b0;
		apb(1'b1, OETC_ADDR_OSC_CTRL, 32'h0);
		@(posedge pclk);
		chk(ext_osc_enable, 1'b0);
		chk(pll_ref_use_osc, 1'b0);
		chk(crystal_pins_claimed, 1'b1);
		apb(1'b0, 12'h004, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		// a second system reset must free the crystal pins again
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(crystal_pins_claimed, 1'b0);
		chk(temp_coeff_trim, OETC_TRIM_RST);
		apb(1'b0, OETC_ADDR_OSC_CTRL, 32'h0);
		chk(rd, 32'h0);
		complete_run();
	end
endmodule // oetc_osc_ctrl_test
`default_nettype wire
